// file: rtl/hidp_pkg.sv
// Functional notes
// - host reaches PM and DM, one cycle each
// - host writes never reach control register space
// - bit15 set loads overlay from bits 7..0
// - bit15 clear loads address, bit14 picks memory
// - one 16-bit muxed bus, 24-bit PM words
// - host side asynchronous, synchronised into clk domain
// - address auto-increments after every completed DM or PM word
// - control word captured when latch combination ends
// - one sync cycle, then one memory cycle
// - overlay at DM 0x3FE0, processor sets address
// - latched address never driven back to host
// - 0x3FE7 bit14 selects short read only timing
package hidp_pkg;

   // Address and data widths
   localparam int ADDR_W          = 14;
   localparam int BUS_W           = 16;
   localparam int PM_W            = 24;

   // Processor-side register offsets (data memory space)
   localparam logic [13:0] OVL_OFF      = 14'h3FE0;
   localparam logic [13:0] TGT_OFF      = 14'h3FE1;
   localparam logic [13:0] MODE_OFF     = 14'h3FE7;
   // Start of control registers that the host may not write
   localparam logic [13:0] CTRL_BASE    = 14'h3FE0;

   // Control word and mode register field positions
   localparam int CW_OVL_BIT      = 15;
   localparam int CW_DEST_BIT     = 14;
   localparam int OVL_PM_LSB      = 0;
   localparam int OVL_DM_LSB      = 4;
   localparam int OVL_FIELD_W     = 4;
   localparam int MODE_SHORT_BIT  = 14;

   // Destination encoding in bit 14 of the control word
   localparam logic DEST_PM       = 1'b0;

   // Reset values
   localparam logic [7:0]  OVL_RST      = 8'h00;
   localparam logic [14:0] TGT_RST      = 15'h0000;
   localparam logic        MODE_RST     = 1'b0;
   // Idle levels of the host pins: select, latch, read, write
   localparam logic [3:0]  PIN_IDLE     = 4'hB;

   // Port sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SYNC,
      ST_ACCESS,
      ST_RDATA,
      ST_HOLD
   } hidp_state_t;

endpackage : hidp_pkg

// file: rtl/hidp_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
// Memory request carrier between the port sequencer and the RAMs
interface hidp_mem_if;
   logic                           re;     // Read strobe, one cycle
   logic                           we;     // Write strobe, one cycle
   logic                           is_pm;  // Target is program memory
   logic [hidp_pkg::ADDR_W-1:0]    addr;   // Word address
   logic [hidp_pkg::PM_W-1:0]      wdata;  // Write data, DM in low bits
   logic [hidp_pkg::PM_W-1:0]      rdata;  // Registered read data

   // Sequencer side
   modport ctrl (output re, output we, output is_pm, output addr,
                 output wdata, input rdata);
   // Memory side
   modport mem  (input re, input we, input is_pm, input addr,
                 input wdata, output rdata);
endinterface : hidp_mem_if
`default_nettype wire

// file: rtl/hidp_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for asynchronous pin levels
module hidp_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_ff;   // First stage, read only by second stage
   logic [WIDTH-1:0] sync_ff;   // Second stage, safe to use

   // Both stages reset to the idle level of the pins
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
      end else begin
         meta_ff <= d;
         sync_ff <= meta_ff;
      end
   end

   assign q = sync_ff;
endmodule : hidp_sync
`default_nettype wire

// file: rtl/hidp_mem.sv
`timescale 1ns/1ps
`default_nettype none
// On-chip program and data RAMs, one shared access port
module hidp_mem #(
   parameter int AW = hidp_pkg::ADDR_W
) (
   input  wire logic clk,
   input  wire logic arst_n,
   hidp_mem_if.mem   m
);
   localparam int DEPTH = 1 << AW;

   logic [hidp_pkg::PM_W-1:0]  pm_mem [DEPTH];  // 24-bit program words
   logic [hidp_pkg::BUS_W-1:0] dm_mem [DEPTH];  // 16-bit data words
   logic [hidp_pkg::PM_W-1:0]  rdata_ff;        // Read data register

   // Array writes, no reset on storage
   always_ff @(posedge clk) begin
      if (m.we && m.is_pm) begin
         pm_mem[m.addr[AW-1:0]] <= m.wdata;
      end
      if (m.we && !m.is_pm) begin
         dm_mem[m.addr[AW-1:0]] <= m.wdata[hidp_pkg::BUS_W-1:0];
      end
   end

   // Registered read, data valid the cycle after the strobe
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_ff <= '0;
      end else if (m.re) begin
         rdata_ff <= m.is_pm ? pm_mem[m.addr[AW-1:0]]
                             : {8'h00, dm_mem[m.addr[AW-1:0]]};
      end
   end

   assign m.rdata = rdata_ff;
endmodule : hidp_mem
`default_nettype wire

// file: rtl/hidp_port.sv
`timescale 1ns/1ps
`default_nettype none
// Host internal memory port: async host pins to on-chip RAM
module hidp_port (
   input  wire logic        clk,
   input  wire logic        arst_n,
   // Host pins
   input  wire logic        port_select_n,
   input  wire logic        addr_latch_strobe,
   input  wire logic        host_read_strobe_n,
   input  wire logic        host_write_strobe_n,
   input  wire logic [15:0] shared_addr_data_bus_i,
   output logic      [15:0] shared_addr_data_bus_o,
   output logic             shared_addr_data_bus_oe,
   output logic             host_port_ack_n,
   // Processor register access
   input  wire logic        cpu_sel,
   input  wire logic        cpu_we,
   input  wire logic [13:0] cpu_addr,
   input  wire logic [15:0] cpu_wdata,
   output logic      [15:0] cpu_rdata,
   // Overlay selections and cycle steal indication
   output logic      [3:0]  program_window_select,
   output logic      [3:0]  data_window_select,
   output logic             cycle_steal
);
   hidp_mem_if mif ();                      // RAM request carrier

   logic [3:0]               pins_s;        // Synced select/latch/rd/wr
   logic [15:0]              bus_s;         // Synced bus value
   logic                     latch_act;     // Select low with latch high
   logic                     rd_act;        // Select and read low
   logic                     wr_act;        // Select and write low
   logic                     latch_act_ff;  // Previous latch level
   logic                     rd_act_ff;     // Previous read level
   logic                     wr_act_ff;     // Previous write level
   logic                     latch_evt;     // Control word complete
   logic                     rd_start;      // Read request leading edge
   logic                     wr_end;        // Write request trailing edge
   logic [15:0]              hold_ff;       // Last bus value while active
   hidp_pkg::hidp_state_t    state_ff;      // Sequencer state
   hidp_pkg::hidp_state_t    nxt_state;     // Next sequencer state
   logic                     op_rd_ff;      // Current op is a read
   logic [14:0]              tgt_ff;        // Dest bit and word address
   logic [7:0]               ovl_ff;        // Overlay selection
   logic                     short_ff;      // Short read only mode
   logic                     half_ff;       // PM low part comes next
   logic [15:0]              pm_hi_ff;      // PM upper 16 bits on write
   logic [7:0]               low_ff;        // PM low byte on read
   logic                     rd_low_ff;     // This read serves low byte
   logic                     rd_incr_ff;    // Read completes a word
   logic [15:0]              out_ff;        // Data driven to host
   logic                     drive_ff;      // Read data is on the bus
   logic                     is_pm;         // Target is program memory
   logic                     incr_now;      // Advance the address
   logic                     cpu_tgt_wr;    // Processor loads target
   logic [15:0]              cw;            // Control word being applied
   logic                     cw_load;       // Apply a control word

   hidp_sync #(.WIDTH(4), .RST_VAL(hidp_pkg::PIN_IDLE)) u_pin_sync (
      .clk    (clk),
      .arst_n (arst_n),
      .d      ({port_select_n, addr_latch_strobe,
                host_read_strobe_n, host_write_strobe_n}),
      .q      (pins_s)
   );

   // Bus is sampled through the same two-flop path
   hidp_sync #(.WIDTH(16), .RST_VAL(16'h0000)) u_bus_sync (
      .clk    (clk),
      .arst_n (arst_n),
      .d      (shared_addr_data_bus_i),
      .q      (bus_s)
   );

   // RAM block shared with the processor
   hidp_mem #(.AW(hidp_pkg::ADDR_W)) u_mem (
      .clk    (clk),
      .arst_n (arst_n),
      .m      (mif.mem)
   );

   // Decode synced pin combinations
   assign latch_act = !pins_s[3] && pins_s[2];
   assign rd_act    = !pins_s[3] && !pins_s[1] && !pins_s[2];
   assign wr_act    = !pins_s[3] && !pins_s[0] && !pins_s[2];
   // latch when strobe falls or select rises
   assign latch_evt = latch_act_ff && !latch_act;
   assign rd_start  = rd_act && !rd_act_ff;
   assign wr_end    = wr_act_ff && !wr_act;
   assign is_pm     = (tgt_ff[hidp_pkg::CW_DEST_BIT] == hidp_pkg::DEST_PM);

   // Edge history of the decoded requests
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         latch_act_ff <= 1'b0;
         rd_act_ff    <= 1'b0;
         wr_act_ff    <= 1'b0;
      end else begin
         latch_act_ff <= latch_act;
         rd_act_ff    <= rd_act;
         wr_act_ff    <= wr_act;
      end
   end

   // Keep the last stable bus value of a latch or write phase
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hold_ff <= 16'h0000;
      end else if (latch_act || wr_act) begin
         hold_ff <= bus_s;
      end
   end

   // Processor write to the target register shares the host decode
   assign cpu_tgt_wr = cpu_sel && cpu_we && (cpu_addr == hidp_pkg::TGT_OFF);
   // Host latch wins over a processor write in the same cycle
   assign cw_load    = latch_evt || cpu_tgt_wr;
   assign cw         = latch_evt ? hold_ff : cpu_wdata;

   // sync cycle then one memory cycle
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         hidp_pkg::ST_IDLE: begin
            // Latching has priority, it only updates registers
            if (!latch_evt && (rd_start || wr_end)) begin
               nxt_state = hidp_pkg::ST_SYNC;
            end
         end
         hidp_pkg::ST_SYNC: begin
            nxt_state = hidp_pkg::ST_ACCESS;
         end
         hidp_pkg::ST_ACCESS: begin
            nxt_state = op_rd_ff ? hidp_pkg::ST_RDATA : hidp_pkg::ST_IDLE;
         end
         hidp_pkg::ST_RDATA: begin
            nxt_state = hidp_pkg::ST_HOLD;
         end
         hidp_pkg::ST_HOLD: begin
            // short read mode skips strobe release
            if (short_ff || !rd_act) begin
               nxt_state = hidp_pkg::ST_IDLE;
            end
         end
         default: begin
            nxt_state = hidp_pkg::ST_IDLE;
         end
      endcase
   end

   // State register and operation kind
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= hidp_pkg::ST_IDLE;
         op_rd_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         if (state_ff == hidp_pkg::ST_IDLE) begin
            op_rd_ff <= rd_start;
         end
      end
   end

   assign incr_now =
      ((state_ff == hidp_pkg::ST_ACCESS) && !op_rd_ff
         && (!is_pm || half_ff))
      || ((state_ff == hidp_pkg::ST_HOLD) && (nxt_state == hidp_pkg::ST_IDLE)
         && rd_incr_ff);

   // address and destination from control word
   // processor may load the target too
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tgt_ff <= hidp_pkg::TGT_RST;
      end else if (cw_load && !cw[hidp_pkg::CW_OVL_BIT]) begin
         tgt_ff <= cw[14:0];
      end else if (incr_now) begin
         tgt_ff[13:0] <= tgt_ff[13:0] + 14'h0001;
      end
   end

   // overlay from bits 7..0, bits 14..8 ignored
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ovl_ff <= hidp_pkg::OVL_RST;
      end else if (cw_load && cw[hidp_pkg::CW_OVL_BIT]) begin
         ovl_ff <= cw[7:0];
      end else if (cpu_sel && cpu_we && (cpu_addr == hidp_pkg::OVL_OFF)) begin
         ovl_ff <= cpu_wdata[7:0];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         short_ff <= hidp_pkg::MODE_RST;
      end else if (cpu_sel && cpu_we && (cpu_addr == hidp_pkg::MODE_OFF)) begin
         short_ff <= cpu_wdata[hidp_pkg::MODE_SHORT_BIT];
      end
   end

   // 24-bit PM word moves as two bus words
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         half_ff    <= 1'b0;
         pm_hi_ff   <= 16'h0000;
         rd_low_ff  <= 1'b0;
         rd_incr_ff <= 1'b0;
      end else if (cw_load && !cw[hidp_pkg::CW_OVL_BIT]) begin
         half_ff <= 1'b0;
      end else if (state_ff == hidp_pkg::ST_ACCESS) begin
         rd_low_ff  <= is_pm && half_ff;
         rd_incr_ff <= !is_pm || half_ff;
         if (is_pm) begin
            half_ff <= !half_ff;
         end
         if (is_pm && !half_ff && !op_rd_ff) begin
            pm_hi_ff <= hold_ff;
         end
      end
   end

   // RAM request: one cycle in the access state
   assign mif.re = (state_ff == hidp_pkg::ST_ACCESS) && op_rd_ff
                   && (!is_pm || !half_ff);
   // no host writes into control register space
   assign mif.we = (state_ff == hidp_pkg::ST_ACCESS) && !op_rd_ff
                   && (is_pm ? half_ff
                             : (tgt_ff[13:0] < hidp_pkg::CTRL_BASE));
   assign mif.is_pm = is_pm;
   assign mif.addr  = tgt_ff[13:0];
   assign mif.wdata = is_pm ? {pm_hi_ff, hold_ff[7:0]}
                            : {8'h00, hold_ff};
   assign cycle_steal = mif.re || mif.we;

   // Read data staging toward the host
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         out_ff <= 16'h0000;
         low_ff <= 8'h00;
      end else if (state_ff == hidp_pkg::ST_RDATA) begin
         if (rd_low_ff) begin
            out_ff <= {8'h00, low_ff};
         end else if (is_pm) begin
            out_ff <= mif.rdata[23:8];
            low_ff <= mif.rdata[7:0];
         end else begin
            out_ff <= mif.rdata[15:0];
         end
      end
   end

   // bus driven only with read data
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         drive_ff <= 1'b0;
      end else if (!rd_act) begin
         drive_ff <= 1'b0;
      end else if (state_ff == hidp_pkg::ST_RDATA) begin
         drive_ff <= 1'b1;
      end
   end

   assign shared_addr_data_bus_o  = out_ff;
   assign shared_addr_data_bus_oe = drive_ff && rd_act;

   // ack low while idle with no edge pending, and in hold in short read mode
   // host waits for ack before the next operation
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         host_port_ack_n <= 1'b0;
      end else begin
         host_port_ack_n <= (nxt_state != hidp_pkg::ST_IDLE)
                            && (nxt_state != hidp_pkg::ST_HOLD || !short_ff);
      end
   end

   // processor readback of overlay and mode
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cpu_rdata <= 16'h0000;
      end else if (cpu_sel && !cpu_we) begin
         case (cpu_addr)
            hidp_pkg::OVL_OFF:  cpu_rdata <= {8'h00, ovl_ff};
            hidp_pkg::MODE_OFF: cpu_rdata <= {1'b0, short_ff, 14'h0000};
            default:            cpu_rdata <= 16'h0000;
         endcase
      end
   end

   assign program_window_select = ovl_ff[hidp_pkg::OVL_PM_LSB +: 4];
   assign data_window_select    = ovl_ff[hidp_pkg::OVL_DM_LSB +: 4];

   // Checks on the sequencer and register behaviour
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   ack_busy_a: assert property (
      (state_ff inside {hidp_pkg::ST_SYNC, hidp_pkg::ST_ACCESS,
                        hidp_pkg::ST_RDATA}) |-> host_port_ack_n)
      else $error("ack low while access pending");

   ctrl_prot_a: assert property (
      (mif.we && !mif.is_pm)
         |-> (mif.addr < hidp_pkg::CTRL_BASE))
      else $error("host write reached control space");

   addr_incr_a: assert property (
      (incr_now && !cw_load)
         |=> (tgt_ff[13:0] == $past(tgt_ff[13:0]) + 14'h0001))
      else $error("address did not advance");

   sync_stage_a: assert property (
      ((state_ff == hidp_pkg::ST_IDLE) && !latch_evt && (rd_start || wr_end))
         |=> (state_ff == hidp_pkg::ST_SYNC) ##1
             (state_ff == hidp_pkg::ST_ACCESS))
      else $error("sync then access sequence broken");

   one_cycle_a: assert property (
      cycle_steal |=> !cycle_steal)
      else $error("memory held longer than one cycle");

   ovl_load_a: assert property (
      (latch_evt && hold_ff[15])
         |=> (ovl_ff == $past(hold_ff[7:0])))
      else $error("overlay not loaded from control word");

   addr_load_a: assert property (
      (latch_evt && !hold_ff[15]) |=> (tgt_ff == $past(hold_ff[14:0])))
      else $error("target address not latched");

   no_readback_a: assert property (
      shared_addr_data_bus_oe |-> (rd_act && !latch_act))
      else $error("bus driven outside a read");

   pm_pair_a: assert property (
      (mif.we && mif.is_pm)
         |-> (mif.wdata[23:8] == pm_hi_ff) && half_ff)
      else $error("PM word written without upper part");

   short_read_a: assert property (
      ((state_ff == hidp_pkg::ST_HOLD) && short_ff)
         |=> (state_ff == hidp_pkg::ST_IDLE) && !host_port_ack_n)
      else $error("short read did not release ack");

   read_walk_c:  cover property (rd_start ##4 shared_addr_data_bus_oe);
   write_walk_c: cover property (wr_end ##2 mif.we);
   ovl_latch_c:  cover property (latch_evt && hold_ff[15]);
   pm_pair_c:    cover property (mif.we && mif.is_pm);

endmodule : hidp_port
`default_nettype wire

// file: tb/hidp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host processor model driving the asynchronous port pins
module hidp_host_model (
   input  wire logic        clk,
   input  wire logic        ack_n,
   input  wire logic [15:0] dev_o,
   input  wire logic        dev_oe,
   output logic             sel_n,
   output logic             latch,
   output logic             rd_n,
   output logic             wr_n,
   output logic      [15:0] bus
);
   logic [15:0] val;   // Last value the host put on the bus
   logic        drv;   // Host drives the bus
   int          late;  // Handshake waits that ran out

   // Wire level: device, host, else inverse of the last host value
   assign bus = dev_oe ? dev_o : (drv ? val : ~val);

   // Idle pins from time zero
   initial begin
      {sel_n, latch, rd_n, wr_n} = hidp_pkg::PIN_IDLE;
      val = 16'h0000;
      drv = 1'b0;
      late = 0;
   end

   // Bounded wait for the acknowledge to reach a level
   task automatic wait_ack(input logic v);
      int n;
      n = 0;
      while (ack_n !== v && n < 40) begin
         @(posedge clk);
         n++;
      end
      if (ack_n !== v) late++;
   endtask : wait_ack

   // Raise a request after the port reports ready, hold four cycles
   // ready before start
   task automatic start(input logic [3:0] p, input logic [15:0] w,
                        input logic d);
      wait_ack(1'b0);
      @(posedge clk);
      {sel_n, latch, rd_n, wr_n} <= p;
      val <= w;
      drv <= d;
      repeat (4) @(posedge clk);
   endtask : start

   task automatic latch_word(input logic [15:0] w);
      start(4'h7, w, 1'b1);
      latch <= 1'b0;
      @(posedge clk);
      sel_n <= 1'b1;
      drv <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : latch_word

   // select with write; returns cycles of busy acknowledge
   task automatic write_word(input logic [15:0] w, output int hi);
      start(4'h2, w, 1'b1);
      {sel_n, wr_n} <= 2'h3;
      @(posedge clk);
      drv <= 1'b0;
      hi = 0;
      wait_ack(1'b1);
      while (ack_n === 1'b1 && hi < 20) begin
         @(posedge clk);
         hi++;
      end
   endtask : write_word

   // select with read; returns acknowledge while data held
   task automatic read_word(output logic am);
      int n;
      start(4'h1, val, 1'b0);
      n = 0;
      while (dev_oe !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      repeat (3) @(posedge clk);
      am = ack_n;
      {sel_n, rd_n} <= 2'h3;
      repeat (4) @(posedge clk);
   endtask : read_word
endmodule : hidp_host_model
`default_nettype wire

// file: tb/host_internal_memory_dma_port_test.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the host memory port
module host_internal_memory_dma_port_test;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        cpu_sel = 1'b0;
   logic        cpu_we = 1'b0;
   logic [13:0] cpu_addr = 14'h0000;
   logic [15:0] cpu_wdata = 16'h0000;
   wire  logic  sel_n, latch, rd_n, wr_n, oe, ack_n, steal;
   wire  logic [15:0] bus_i, bus_o, cpu_rdata;
   wire  logic [3:0]  pw, dw;
   logic [15:0] rd_q [$];    // Expected host read words
   logic [15:0] cr_q [$];    // Expected processor read words
   logic        cpu_pend = 1'b0;
   logic        oe_d = 1'b0;
   logic        short_m = 1'b0; // Short read mode programmed
   int          steals = 0;
   int          failures = 0;
   int          checks = 0;

   // Clock at 100 MHz
   always #5 clk = ~clk;

   hidp_port dut_u (.clk(clk), .arst_n(arst_n), .port_select_n(sel_n),
      .addr_latch_strobe(latch), .host_read_strobe_n(rd_n),
      .host_write_strobe_n(wr_n), .shared_addr_data_bus_i(bus_i),
      .shared_addr_data_bus_o(bus_o), .shared_addr_data_bus_oe(oe),
      .host_port_ack_n(ack_n), .cpu_sel(cpu_sel), .cpu_we(cpu_we),
      .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
      .program_window_select(pw), .data_window_select(dw),
      .cycle_steal(steal));

   hidp_host_model host_u (.clk(clk), .ack_n(ack_n), .dev_o(bus_o),
      .dev_oe(oe), .sel_n(sel_n), .latch(latch), .rd_n(rd_n),
      .wr_n(wr_n), .bus(bus_i));

   // Count one comparison, report a mismatch
   task automatic chk(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1) begin
         failures++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask : chk

   // Verdict and end of run
   task automatic tally_and_finish;
      if (failures == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish

   // Watchdog against a hung handshake
   initial begin
      #400000;
      failures++;
      tally_and_finish;
   end

   // Results are compared with the oldest note as they appear
   always @(posedge clk) begin
      if (cpu_pend && cr_q.size() > 0)
         chk(cpu_rdata === cr_q.pop_front(), "cpu read data");
      if (oe === 1'b1 && oe_d !== 1'b1 && rd_q.size() > 0)
         chk(bus_o === rd_q.pop_front(), "host read data");
      if (latch === 1'b1)
         chk(oe === 1'b0, "bus driven in latch");
      if (steal === 1'b1) steals++;
      cpu_pend <= cpu_sel && !cpu_we;
      oe_d <= oe;
   end

   // One processor register access; a read notes its expected word
   task automatic cpu_acc(input logic we, input logic [13:0] a,
                          input logic [15:0] d);
      @(posedge clk);
      cpu_sel <= 1'b1;
      cpu_we <= we;
      cpu_addr <= a;
      cpu_wdata <= d;
      if (!we) cr_q.push_back(d);
      @(posedge clk);
      cpu_sel <= 1'b0;
      @(posedge clk);
   endtask : cpu_acc

   // Write n random units from address a, then read them back
   task automatic run_blk(input logic pm, input logic [13:0] a,
                          input int n);
      logic [23:0] d [$];
      logic [15:0] cw;
      logic        am;
      int          hi;
      int          s0;
      cw = {1'b0, pm ? hidp_pkg::DEST_PM : ~hidp_pkg::DEST_PM, a};
      host_u.latch_word(cw);
      for (int k = 0; k < n; k++) begin
         d.push_back(24'($urandom));
         s0 = steals;
         host_u.write_word(pm ? d[k][23:8] : d[k][15:0], hi);
         chk(hi === 2, "busy span on write");
         if (!pm) chk(steals - s0 === 1, "steal per write");
         if (pm) host_u.write_word({8'h00, d[k][7:0]}, hi);
         if (pm) chk(hi === 2, "busy span on low part");
      end
      host_u.latch_word(cw);
      for (int k = 0; k < n; k++) begin
         rd_q.push_back(pm ? d[k][23:8] : d[k][15:0]);
         host_u.read_word(am);
         chk(am === !short_m, "ack with read held");
         if (pm) rd_q.push_back({8'h00, d[k][7:0]});
         if (pm) host_u.read_word(am);
      end
   endtask : run_blk

   // Main sequence
   initial begin
      logic [7:0] ov;
      int         hi;
      int         s0;
      void'($urandom(32'hFFD4));
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      chk(ack_n === 1'b0 && oe === 1'b0, "idle pins");
      chk({dw, pw} === hidp_pkg::OVL_RST, "window reset");
      cpu_acc(1'b0, hidp_pkg::OVL_OFF, 16'h0000);
      cpu_acc(1'b0, hidp_pkg::MODE_OFF, 16'h0000);
      for (int k = 0; k < 3; k++) begin
         ov = 8'($urandom);
         host_u.latch_word({1'b1, 7'h00, ov});
         chk({dw, pw} === ov, "overlay from host word");
         cpu_acc(1'b0, hidp_pkg::OVL_OFF, {8'h00, ov});
      end
      cpu_acc(1'b1, hidp_pkg::OVL_OFF, 16'hFF3C);
      chk({dw, pw} === 8'h3C, "overlay from cpu");
      cpu_acc(1'b1, hidp_pkg::TGT_OFF, 16'h8096);
      chk({dw, pw} === 8'h96, "format from cpu");
      cpu_acc(1'b0, hidp_pkg::TGT_OFF, 16'h0000);
      cpu_acc(1'b0, 14'h3FE5, 16'h0000);
      run_blk(1'b0, 14'($urandom_range(32'h3F00)), 4);
      run_blk(1'b1, 14'h3FFF, 2);
      run_blk(1'b0, 14'h3FDF, 1);
      host_u.latch_word({2'h1, hidp_pkg::OVL_OFF});
      s0 = steals;
      host_u.write_word(16'h00A5, hi);
      chk(hi === 2, "busy span on guarded write");
      chk(steals === s0, "steal on guarded write");
      cpu_acc(1'b0, hidp_pkg::OVL_OFF, 16'h0096);
      cpu_acc(1'b1, hidp_pkg::MODE_OFF, 16'h4000);
      cpu_acc(1'b0, hidp_pkg::MODE_OFF, 16'h4000);
      short_m = 1'b1;
      run_blk(1'b0, 14'($urandom_range(32'h3F00)), 3);
      run_blk(1'b1, 14'($urandom_range(32'h3F00)), 2);
      repeat (10) @(posedge clk);
      chk(rd_q.size() + cr_q.size() === 0, "notes left over");
      chk(host_u.late === 0, "handshake wait ran out");
      tally_and_finish;
   end
endmodule : host_internal_memory_dma_port_test
`default_nettype wire
